// file: rtl/scfp_defs.svh
`ifndef SCFP_DEFS_SVH
`define SCFP_DEFS_SVH
// Clock rate in MHz.
`define SCFP_CLK_MHZ 125
// Filter and timer figures in their own units.
`define SCFP_SHORT_SENSE_US 60
`define SCFP_REFRESH_MS 14
`define SCFP_ON_OPEN_SENSE_MS 12
`define SCFP_OFF_OPEN_SENSE_US 60
`define SCFP_NEG_FILTER_US 60
`define SCFP_SHORT_BLANK_US 5
`define SCFP_LONG_BLANK_US 15
// Cycle counts derived from the clock rate.
`define SCFP_SHORT_SENSE_CYC (`SCFP_SHORT_SENSE_US * `SCFP_CLK_MHZ)
`define SCFP_REFRESH_CYC (`SCFP_REFRESH_MS * 1000 * `SCFP_CLK_MHZ)
`define SCFP_ON_OPEN_CYC (`SCFP_ON_OPEN_SENSE_MS * 1000 * `SCFP_CLK_MHZ)
`define SCFP_OFF_OPEN_CYC (`SCFP_OFF_OPEN_SENSE_US * `SCFP_CLK_MHZ)
`define SCFP_NEG_FILTER_CYC (`SCFP_NEG_FILTER_US * `SCFP_CLK_MHZ)
`define SCFP_SHORT_BLANK_CYC (`SCFP_SHORT_BLANK_US * `SCFP_CLK_MHZ)
`define SCFP_LONG_BLANK_CYC (`SCFP_LONG_BLANK_US * `SCFP_CLK_MHZ)
// Command code for 50 mA: 50/1230 of 1024 steps with a 1 ohm sense resistor.
`define SCFP_LOW_CURRENT_CODE 10'h02A
// Register offsets.
`define SCFP_ADDR_CMD0 4'h0
`define SCFP_ADDR_CMD1 4'h1
`define SCFP_ADDR_CFG0 4'h2
`define SCFP_ADDR_CFG1 4'h3
`define SCFP_ADDR_FAULT 4'h4
`define SCFP_ADDR_STATE 4'h5
// Configuration field positions.
`define SCFP_CFG_SLEW_LO 0
`define SCFP_CFG_TYPE_BIT 2
// Fault register field positions, channel n at 4*n.
`define SCFP_FLT_OC 0
`define SCFP_FLT_OG 1
`define SCFP_FLT_OT 2
`define SCFP_CFG_RESET 3'h0
`endif

// file: rtl/scfp_pkg.sv
package scfp_pkg;
   typedef enum logic [2:0] {
      SCFP_RUN     = 3'b001,
      SCFP_REFRESH = 3'b010,
      SCFP_HOT     = 3'b100
   } scfp_state_e;
   typedef logic [31:0] scfp_count_t;
endpackage

// file: rtl/scfp_protect.sv
// Functional notes
// - Gate on: overcurrent held past short sense time turns the driver off.
// - Overcurrent shutdown sets a fault bit kept until the fault register is read.
// - After shutdown stay off for the refresh time, then restart automatically.
// - A persisting overcurrent after restart trips again and refreshes again.
// - Overcurrent comparator ignored during blanking after each off-to-on switch.
// - Blanking is 5 us for slew 0 or 1, 15 us for slew 2 or 3.
// - Commands written during refresh are stored and applied once it ends.
// - Each channel has its own detection, refresh timing and fault bits.
// - No overcurrent fault while the current command is below 50 mA.
// - Above 50 mA, driver on past on-state open time sets open fault.
// - Above 50 mA, driver off, negative sense low past filter sets open fault.
// - Below 50 mA, positive low past off time or negative low sets open fault.
// - Fault-typing bit selects the positive pin pull-up, else pull-down.
// - Typing bit writes never change driver state or regulated current.
// - With zero command a short to ground still sets the open fault.
// - Overtemperature turns the channel off and flags it; restart when cleared.
// - Thermal fault bit per channel, kept until the host reads it.
// - The default input resets registers but keeps the fault bits.
// - Power-on reset clears fault bits and forces the command to zero.
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defs.svh"
module scfp_protect
   import scfp_pkg::*;
#(
   parameter int CHANNELS    = 2,
   parameter int REFRESH_CYC = `SCFP_REFRESH_CYC,
   parameter int ON_OPEN_CYC = `SCFP_ON_OPEN_CYC
) (
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Default input.
   input  wire logic                defaultIn,
   // Register port.
   input  wire logic [3:0]          regAddr,
   input  wire logic [15:0]         regWrData,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic      [15:0]         regRdData,
   // Channel requests and comparators.
   input  wire logic [CHANNELS-1:0] regulateOn,
   input  wire logic [CHANNELS-1:0] posOverCurrent,
   input  wire logic [CHANNELS-1:0] posBelowOpen,
   input  wire logic [CHANNELS-1:0] negativeSenseLow,
   input  wire logic [CHANNELS-1:0] overTemp,
   // Channel outputs.
   output logic      [CHANNELS-1:0] gateEnable,
   output logic      [CHANNELS-1:0] posPullUp,
   output logic      [CHANNELS-1:0] posPullDown,
   output logic      [CHANNELS-1:0] overcurrentFaultBit,
   output logic      [CHANNELS-1:0] openOrGroundFaultBit,
   output logic      [CHANNELS-1:0] thermalFaultBit
);
   localparam int ELEN = 2;

   function automatic logic cmdHigh(input logic [9:0] cmd);
      cmdHigh = cmd > `SCFP_LOW_CURRENT_CODE;
   endfunction

   function automatic scfp_count_t step(input logic cond, input scfp_count_t c,
                                        input scfp_count_t lim);
      if (!cond) begin
         step = '0;
      end else if (c < lim) begin
         step = c + 32'h1;
      end else begin
         step = c;
      end
   endfunction

   logic [9:0]        cmdReg   [CHANNELS];
   logic [9:0]        cmdNext  [CHANNELS];
   logic [2:0]        cfgReg   [CHANNELS];
   logic [2:0]        cfgNext  [CHANNELS];
   scfp_state_e       stReg    [CHANNELS];
   scfp_state_e       stNext   [CHANNELS];
   scfp_count_t       ocCnt_reg   [CHANNELS];
   scfp_count_t       ocCnt_next  [CHANNELS];
   scfp_count_t       blCnt_reg   [CHANNELS];
   scfp_count_t       blCnt_next  [CHANNELS];
   scfp_count_t       refCnt_reg  [CHANNELS];
   scfp_count_t       refCnt_next [CHANNELS];
   scfp_count_t       onCnt_reg   [CHANNELS];
   scfp_count_t       onCnt_next  [CHANNELS];
   scfp_count_t       posCnt_reg  [CHANNELS];
   scfp_count_t       posCnt_next [CHANNELS];
   scfp_count_t       negCnt_reg  [CHANNELS];
   scfp_count_t       negCnt_next [CHANNELS];
   logic [CHANNELS-1:0] gate_reg;
   logic [CHANNELS-1:0] gate_next;
   logic [CHANNELS-1:0] oc_reg;
   logic [CHANNELS-1:0] oc_next;
   logic [CHANNELS-1:0] og_reg;
   logic [CHANNELS-1:0] og_next;
   logic [CHANNELS-1:0] ot_reg;
   logic [CHANNELS-1:0] ot_next;
   logic [15:0]         rd_reg;
   logic [15:0]         rd_next;

   always_comb begin
      logic readFault;
      logic hi;
      logic want;
      logic trip;
      readFault = regRead && (regAddr == `SCFP_ADDR_FAULT);
      hi        = 1'b0;
      want      = 1'b0;
      trip      = 1'b0;
      gate_next = gate_reg;
      oc_next   = oc_reg;
      og_next   = og_reg;
      ot_next   = ot_reg;
      rd_next   = 16'h0000;
      for (int n = 0; n < CHANNELS; n++) begin
         cmdNext[n]     = cmdReg[n];
         cfgNext[n]     = cfgReg[n];
         stNext[n]      = stReg[n];
         ocCnt_next[n]  = ocCnt_reg[n];
         blCnt_next[n]  = blCnt_reg[n];
         refCnt_next[n] = refCnt_reg[n];
         if (regWrite && regAddr == `SCFP_ADDR_CMD0 + 4'(n)) begin
            cmdNext[n] = regWrData[9:0];
         end
         if (regWrite && regAddr == `SCFP_ADDR_CFG0 + 4'(n)) begin
            cfgNext[n] = regWrData[2:0];
         end
         if (defaultIn) begin
            cmdNext[n] = 10'h000;
            cfgNext[n] = `SCFP_CFG_RESET;
         end
         hi   = cmdHigh(cmdReg[n]);
         want = regulateOn[n] && (cmdReg[n] != 10'h000);
         trip = 1'b0;
         case (stReg[n])
            SCFP_RUN: begin
               gate_next[n] = want;
               if (want && !gate_reg[n]) begin
                  blCnt_next[n] = cfgReg[n][1] ? `SCFP_LONG_BLANK_CYC : `SCFP_SHORT_BLANK_CYC;
               end else if (blCnt_reg[n] != '0) begin
                  blCnt_next[n] = blCnt_reg[n] - 32'h1;
               end
               ocCnt_next[n] = step(gate_reg[n] && blCnt_reg[n] == '0 && posOverCurrent[n],
                                    ocCnt_reg[n], `SCFP_SHORT_SENSE_CYC);
               if (hi && ocCnt_reg[n] >= `SCFP_SHORT_SENSE_CYC) begin
                  oc_next[n]     = 1'b1;
                  gate_next[n]   = 1'b0;
                  stNext[n]      = SCFP_REFRESH;
                  refCnt_next[n] = '0;
                  ocCnt_next[n]  = '0;
                  trip           = 1'b1;
               end
            end
            SCFP_REFRESH: begin
               gate_next[n]   = 1'b0;
               refCnt_next[n] = refCnt_reg[n] + 32'h1;
               if (refCnt_reg[n] >= REFRESH_CYC - 1) begin
                  stNext[n] = SCFP_RUN;
               end
            end
            default: begin
               gate_next[n] = 1'b0;
               if (!overTemp[n]) begin
                  stNext[n] = SCFP_RUN;
               end
            end
         endcase
         if (overTemp[n]) begin
            stNext[n]    = SCFP_HOT;
            gate_next[n] = 1'b0;
         end
         onCnt_next[n]  = step(hi && gate_reg[n], onCnt_reg[n], ON_OPEN_CYC);
         // Negative filter in all modes but driver on with high command.
         negCnt_next[n] = step(!(hi && gate_reg[n]) && negativeSenseLow[n], negCnt_reg[n],
                               `SCFP_NEG_FILTER_CYC);
         posCnt_next[n] = step(!hi && posBelowOpen[n], posCnt_reg[n], `SCFP_OFF_OPEN_CYC);
         if (readFault) begin
            oc_next[n] = 1'b0;
            og_next[n] = 1'b0;
            ot_next[n] = 1'b0;
            rd_next[4*n+`SCFP_FLT_OC] = oc_reg[n];
            rd_next[4*n+`SCFP_FLT_OG] = og_reg[n];
            rd_next[4*n+`SCFP_FLT_OT] = ot_reg[n];
         end
         if (trip) begin
            oc_next[n] = 1'b1;
         end
         if (onCnt_reg[n] >= ON_OPEN_CYC || negCnt_reg[n] >= `SCFP_NEG_FILTER_CYC ||
             posCnt_reg[n] >= `SCFP_OFF_OPEN_CYC) begin
            og_next[n] = 1'b1;
         end
         if (overTemp[n]) begin
            ot_next[n] = 1'b1;
         end
         if (regRead && regAddr == `SCFP_ADDR_CMD0 + 4'(n)) begin
            rd_next = {6'h00, cmdReg[n]};
         end
         if (regRead && regAddr == `SCFP_ADDR_CFG0 + 4'(n)) begin
            rd_next = {13'h0000, cfgReg[n]};
         end
         if (regRead && regAddr == `SCFP_ADDR_STATE) begin
            rd_next[4*n +: 3] = stReg[n];
            rd_next[4*n+3]    = gate_reg[n];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_reg <= '0;
         oc_reg   <= '0;
         og_reg   <= '0;
         ot_reg   <= '0;
         rd_reg   <= 16'h0000;
         for (int n = 0; n < CHANNELS; n++) begin
            cmdReg[n]     <= 10'h000;
            cfgReg[n]     <= `SCFP_CFG_RESET;
            stReg[n]      <= SCFP_RUN;
            ocCnt_reg[n]  <= '0;
            blCnt_reg[n]  <= '0;
            refCnt_reg[n] <= '0;
            onCnt_reg[n]  <= '0;
            posCnt_reg[n] <= '0;
            negCnt_reg[n] <= '0;
         end
      end else begin
         gate_reg <= gate_next;
         oc_reg   <= oc_next;
         og_reg   <= og_next;
         ot_reg   <= ot_next;
         rd_reg   <= rd_next;
         for (int n = 0; n < CHANNELS; n++) begin
            cmdReg[n]     <= cmdNext[n];
            cfgReg[n]     <= cfgNext[n];
            stReg[n]      <= stNext[n];
            ocCnt_reg[n]  <= ocCnt_next[n];
            blCnt_reg[n]  <= blCnt_next[n];
            refCnt_reg[n] <= refCnt_next[n];
            onCnt_reg[n]  <= onCnt_next[n];
            posCnt_reg[n] <= posCnt_next[n];
            negCnt_reg[n] <= negCnt_next[n];
         end
      end
   end

   logic [CHANNELS-1:0] pu_reg;
   logic [CHANNELS-1:0] pu_next;
   logic [CHANNELS-1:0] pd_reg;
   logic [CHANNELS-1:0] pd_next;

   // Both bias pins leave their own flop, so the pull-down is on after reset.
   always_comb begin
      for (int n = 0; n < CHANNELS; n++) begin
         pu_next[n] = cfgNext[n][`SCFP_CFG_TYPE_BIT];
      end
      pd_next = ~pu_next;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_reg <= '0;
         pd_reg <= '1;
      end else begin
         pu_reg <= pu_next;
         pd_reg <= pd_next;
      end
   end

   assign gateEnable           = gate_reg;
   assign posPullUp            = pu_reg;
   assign posPullDown          = pd_reg;
   assign overcurrentFaultBit  = oc_reg;
   assign openOrGroundFaultBit = og_reg;
   assign thermalFaultBit      = ot_reg;
   assign regRdData            = rd_reg;
endmodule
`default_nettype wire

// file: tb/scfp_protect_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defs.svh"
module scfp_protect_props
   import scfp_pkg::*;
#(
   parameter int CHANNELS    = 2,
   parameter int REFRESH_CYC = 200,
   parameter int ON_OPEN_CYC = 300
) (
   // Clock, reset and register port.
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic [3:0]          regAddr,
   input wire logic                regRead,
   input wire logic [15:0]         regRdData,
   // Channel signals.
   input wire logic [CHANNELS-1:0] regulateOn,
   input wire logic [CHANNELS-1:0] overTemp,
   input wire logic [CHANNELS-1:0] gateEnable,
   input wire logic [CHANNELS-1:0] posPullUp,
   input wire logic [CHANNELS-1:0] posPullDown,
   input wire logic [CHANNELS-1:0] overcurrentFaultBit,
   input wire logic [CHANNELS-1:0] thermalFaultBit
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_PULL_PAIR: assert property (posPullDown == ~posPullUp)
      else $error("Pull-down is not the inverse of pull-up.");
   AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("Read data not zero outside a read answer.");
   AST_OC_CUTS: assert property ($rose(overcurrentFaultBit[0]) |-> ##[0:1] !gateEnable[0])
      else $error("Gate still on after overcurrent trip.");
   AST_OC_HOLD: assert property ($rose(overcurrentFaultBit[0]) |-> ##2 (!gateEnable[0])[*8])
      else $error("Gate back on early in refresh.");
   AST_OC_CLEAR: assert property ($fell(overcurrentFaultBit[0])
      |-> $past(regRead) && $past(regAddr) == `SCFP_ADDR_FAULT)
      else $error("Overcurrent flag cleared without a fault read.");
   AST_OT_CLEAR: assert property ($fell(thermalFaultBit[1])
      |-> $past(regRead) && $past(regAddr) == `SCFP_ADDR_FAULT)
      else $error("Thermal flag cleared without a fault read.");
   AST_OT_FLAG: assert property (overTemp[1] |=> thermalFaultBit[1])
      else $error("Thermal flag not set after overtemperature.");
   AST_OT_OFF: assert property (overTemp[1][*3] |-> !gateEnable[1])
      else $error("Gate on during overtemperature.");
   AST_GATE_REQ: assert property (gateEnable[0] |-> $past(regulateOn[0]))
      else $error("Gate on without a regulator request.");
   AST_BLANK: assert property ($rose(gateEnable[0]) |=> (!$rose(overcurrentFaultBit[0]))[*8])
      else $error("Overcurrent flagged inside blanking.");
   cover property ($rose(overcurrentFaultBit[0]));
   cover property ($rose(thermalFaultBit[1]));
   cover property ($rose(regRead));
endmodule
bind scfp_protect scfp_protect_props #(.CHANNELS(CHANNELS), .REFRESH_CYC(REFRESH_CYC),
   .ON_OPEN_CYC(ON_OPEN_CYC)) scfp_protect_props_i (.clk, .rst_n, .regAddr, .regRead,
   .regRdData, .regulateOn, .overTemp, .gateEnable, .posPullUp, .posPullDown,
   .overcurrentFaultBit, .thermalFaultBit);
`default_nettype wire

// file: tb/scfp_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module scfp_load_model (
   // Driver side.
   input  wire logic [1:0] gateEnable,
   input  wire logic [1:0] posPullUp,
   // Injected load faults.
   input  wire logic [1:0] openLoad,
   input  wire logic [1:0] shortBat,
   input  wire logic [1:0] shortGnd,
   input  wire logic [1:0] hot,
   // Comparator outputs.
   output logic      [1:0] posOverCurrent,
   output logic      [1:0] posBelowOpen,
   output logic      [1:0] negativeSenseLow,
   output logic      [1:0] overTemp
);
   // An open pin follows the bias source; a ground short always reads low.
   assign posBelowOpen = shortGnd | (openLoad & ~posPullUp);
   assign negativeSenseLow = posBelowOpen & ~gateEnable;
   assign posOverCurrent = gateEnable & shortBat;
   assign overTemp = hot;
endmodule
`default_nettype wire

// file: tb/scfp_protect_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "scfp_defs.svh"
module scfp_protect_tb;
   import scfp_pkg::*;
   localparam int RCYC = 200;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        defaultIn = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [1:0]  regulateOn = 2'h0;
   logic [1:0]  openLoad = 2'h0;
   logic [1:0]  shortBat = 2'h0;
   logic [1:0]  shortGnd = 2'h0;
   logic [1:0]  hot = 2'h0;
   wire  [15:0] regRdData;
   wire  [1:0]  pOc, pLow, nLow, oT, gate, pUp, pDn, fOc, fOg, fOt;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   scfp_protect #(.REFRESH_CYC(RCYC), .ON_OPEN_CYC(300)) scfp_protect_i (.clk(clk),
      .rst_n(rst_n), .defaultIn(defaultIn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .regulateOn(regulateOn), .posOverCurrent(pOc), .posBelowOpen(pLow),
      .negativeSenseLow(nLow), .overTemp(oT), .gateEnable(gate), .posPullUp(pUp),
      .posPullDown(pDn), .overcurrentFaultBit(fOc), .openOrGroundFaultBit(fOg),
      .thermalFaultBit(fOt));
   scfp_load_model scfp_load_model_i (.gateEnable(gate), .posPullUp(pUp),
      .openLoad(openLoad), .shortBat(shortBat), .shortGnd(shortGnd), .hot(hot),
      .posOverCurrent(pOc), .posBelowOpen(pLow), .negativeSenseLow(nLow), .overTemp(oT));
   task automatic conclude();
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         $display("Error at %0t: run did not finish", $time);
         conclude();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk(regRdData & m, e);
      @(posedge clk);
   endtask
   task automatic t_oc();
      int n;
      wr(`SCFP_ADDR_CMD0, 16'h0100);
      wr(`SCFP_ADDR_CMD1, 16'h0100);
      regulateOn <= 2'h3;
      wt(290);
      chk({15'h0, fOg[0]}, 16'h0000);
      wt(410);
      chk({15'h0, fOg[0]}, 16'h0001);
      shortBat <= 2'h1;
      for (n = 0; n < 9000 && fOc[0] !== 1'b1; n++) @(negedge clk);
      chk({15'h0, n >= 7495 && n <= 7510}, 16'h0001);
      chk({14'h0, gate}, 16'h0002);
      @(posedge clk);
      rdc(`SCFP_ADDR_STATE, 16'h00FF, 16'h0092);
      wr(`SCFP_ADDR_CMD0, 16'h01FF);
      for (n = 0; n < 1000 && gate[0] !== 1'b1; n++) @(negedge clk);
      chk({15'h0, n >= RCYC - 6 && n <= RCYC + 4}, 16'h0001);
      @(posedge clk);
      rdc(`SCFP_ADDR_FAULT, 16'h0011, 16'h0001);
      rdc(`SCFP_ADDR_FAULT, 16'h0001, 16'h0000);
      for (n = 0; n < 9000 && fOc[0] !== 1'b1; n++) @(negedge clk);
      chk({15'h0, fOc[0]}, 16'h0001);
      @(posedge clk);
      shortBat <= 2'h0;
      rdc(`SCFP_ADDR_CMD0, 16'h03FF, 16'h01FF);
      rdc(`SCFP_ADDR_FAULT, 16'h0077, 16'h0023);
   endtask
   task automatic t_low();
      wt(300);
      wr(`SCFP_ADDR_CMD0, 16'h002A);
      shortBat <= 2'h1;
      wt(9000);
      chk({15'h0, fOc[0]}, 16'h0000);
      shortBat <= 2'h0;
      wr(`SCFP_ADDR_CMD0, 16'h0100);
      wt(700);
      shortBat <= 2'h1;
      wt(5000);
      shortBat <= 2'h0;
      wt(2);
      shortBat <= 2'h1;
      wt(5000);
      shortBat <= 2'h0;
      chk({15'h0, fOc[0]}, 16'h0000);
   endtask
   task automatic t_type();
      wr(`SCFP_ADDR_CMD0, 16'h0000);
      shortGnd <= 2'h1;
      wr(`SCFP_ADDR_CFG0, 16'h0004);
      wr(`SCFP_ADDR_CFG0, 16'h0004);
      wr(`SCFP_ADDR_CFG0, 16'h0004);
      rdc(`SCFP_ADDR_FAULT, 16'h0077, 16'h0022);
      @(negedge clk);
      chk({14'h0, pUp[0], pDn[0] | gate[0]}, 16'h0002);
      wt(7600);
      rdc(`SCFP_ADDR_FAULT, 16'h0002, 16'h0002);
      shortGnd <= 2'h0;
      openLoad <= 2'h1;
      wt(2);
      rdc(`SCFP_ADDR_FAULT, 16'h0002, 16'h0002);
      wt(7600);
      rdc(`SCFP_ADDR_FAULT, 16'h0002, 16'h0000);
      wr(`SCFP_ADDR_CFG0, 16'h0000);
      @(negedge clk);
      chk({15'h0, pDn[0]}, 16'h0001);
      wt(7600);
      rdc(`SCFP_ADDR_FAULT, 16'h0002, 16'h0002);
      openLoad <= 2'h0;
   endtask
   task automatic t_ot();
      hot <= 2'h2;
      wt(4);
      rdc(`SCFP_ADDR_FAULT, 16'h0040, 16'h0040);
      @(negedge clk);
      chk({14'h0, gate[1], fOt[1]}, 16'h0001);
      @(posedge clk);
      hot <= 2'h0;
      wt(4);
      chk({15'h0, gate[1]}, 16'h0001);
      rdc(`SCFP_ADDR_FAULT, 16'h0040, 16'h0040);
      rdc(`SCFP_ADDR_FAULT, 16'h0040, 16'h0000);
   endtask
   task automatic t_def();
      hot <= 2'h2;
      wt(2);
      hot <= 2'h0;
      defaultIn <= 1'b1;
      wt(2);
      rdc(`SCFP_ADDR_CMD1, 16'h03FF, 16'h0000);
      rdc(`SCFP_ADDR_FAULT, 16'h0040, 16'h0040);
      defaultIn <= 1'b0;
      rdc(4'hF, 16'hFFFF, 16'h0000);
   endtask
   task automatic t_slew();
      int n;
      wr(`SCFP_ADDR_CFG1, 16'h0002);
      wr(`SCFP_ADDR_CMD1, 16'h0100);
      shortBat <= 2'h2;
      for (n = 0; n < 12000 && fOc[1] !== 1'b1; n++) @(negedge clk);
      chk({15'h0, n >= 9370 && n <= 9385}, 16'h0001);
      @(posedge clk);
      shortBat <= 2'h0;
   endtask
   initial begin
      wt(16);
      chk({6'h0, fOc, fOg, fOt, gate, pDn}, 16'h0003);
      rst_n <= 1'b1;
      wt(1);
      rdc(`SCFP_ADDR_CMD0, 16'h03FF, 16'h0000);
      t_oc();
      t_low();
      t_type();
      t_ot();
      t_def();
      t_slew();
      conclude();
   end
endmodule
`default_nettype wire
